//--- ebu_defs.vh
// Constants for the external bus unit: configuration fields, timing counts.
// Assumes inclusion by the bus unit and its window decoder only.
`ifndef EBU_DEFS_VH
`define EBU_DEFS_VH

// =====================================================================
// Widths
`define EBU_AW          24
`define EBU_DW          16
`define EBU_NWIN        4
`define EBU_NCS         5
`define EBU_CFGW        16
`define EBU_CNTW        4

// =====================================================================
// Window select register fields
`define EBU_SEL_BASE_HI 15
`define EBU_SEL_BASE_LO 4
`define EBU_SEL_RNG_HI  3
`define EBU_SEL_RNG_LO  0
`define EBU_ADDR_WIN_LO 12
`define EBU_RNG_ONE     12'h001

// =====================================================================
// Bus configuration register fields
`define EBU_CFG_MCT_HI  3
`define EBU_CFG_MCT_LO  0
`define EBU_CFG_TRI     4
`define EBU_CFG_ALE_EXT 5
`define EBU_CFG_RW_DLY  6
`define EBU_CFG_MODE_HI 8
`define EBU_CFG_MODE_LO 7
`define EBU_CFG_RDY_EN  9
`define EBU_CFG_ACT     10
`define EBU_CFG_RESET   16'h0000

// Bus mode codes: bit 0 is multiplexed, bit 1 is 16-bit data.
`define EBU_MODE_MUX    0
`define EBU_MODE_W16    1

// =====================================================================
// System configuration and status word fields
`define EBU_SYS_UNLATCHED_CS_CFG   6
`define EBU_SYS_SPC_HI  10
`define EBU_SYS_SPC_LO  9
`define EBU_PSW_ARB_EN  10

// Address space codes.
`define EBU_SPC_64K     2'h0
`define EBU_SPC_256K    2'h1
`define EBU_SPC_1M      2'h2
`define EBU_SPC_16M     2'h3
`define EBU_UPM_64K     8'h00
`define EBU_UPM_256K    8'h03
`define EBU_UPM_1M      8'h0f
`define EBU_UPM_16M     8'hff

// =====================================================================
// Timing counts in cycles
`define EBU_ALE_SHORT   4'h0
`define EBU_ALE_LONG    4'h1
`define EBU_CNT_ZERO    4'h0
`define EBU_CNT_ONE     4'h1

`endif

//--- ebu_window_decode.v
// Address window decoder of the external bus unit.
// Assumes window settings are static while an access runs.
`include "ebu_defs.vh"
module ebu_window_decode (
    input  wire [`EBU_AW-1:0]           addr,
    input  wire [`EBU_NWIN*16-1:0]      sel_regs,
    input  wire [`EBU_NWIN-1:0]         win_act,
    output reg  [`EBU_NCS-1:0]          win_hit
);

    // =================================================================
    // Window match
    function win_match;
        input [`EBU_AW-1:0] a;
        input [15:0]        sel;
        reg   [11:0]        mask;
        begin
            mask = ~((`EBU_RNG_ONE << sel[`EBU_SEL_RNG_HI:`EBU_SEL_RNG_LO])
                     - `EBU_RNG_ONE);
            win_match = (((a[`EBU_AW-1:`EBU_ADDR_WIN_LO]
                        ^ sel[`EBU_SEL_BASE_HI:`EBU_SEL_BASE_LO]) & mask)
                        == 12'h000);
        end
    endfunction

    // =================================================================
    // Priority selection
    reg [`EBU_NWIN-1:0] m;
    integer i;
    always @* begin
        m = {`EBU_NWIN{1'b0}};
        for (i = 0; i < `EBU_NWIN; i = i + 1) begin
            m[i] = win_act[i] & win_match(addr, sel_regs[i*16 +: 16]);
        end
        win_hit = 5'h00;
        if (m[3]) begin
            win_hit = 5'h10;
        end else if (m[2]) begin
            win_hit = 5'h08;
        end else if (m[1]) begin
            win_hit = 5'h04;
        end else if (m[0]) begin
            win_hit = 5'h02;
        end else begin
            win_hit = 5'h01;
        end
    end

endmodule // ebu_window_decode

//--- ebu_external_bus_unit.v
// External bus unit: runs processor accesses on the external bus pins.
// Assumes config ports are static between accesses; pins are synchronous.
//
// Overview of operation
// - Single-chip mode or four external modes with 16 to 24 address bits.
// - Demultiplexed: address on address port, data on data port or low byte.
// - Multiplexed: data port carries address then data in one cycle.
// - Cycle time, tri-state time, latch pulse and read/write delay programmable.
// - Four windows, each a select register paired with a bus configuration.
// - Window four beats three, window two beats one on overlap.
// - Addresses outside every window use the default bus configuration.
// - Five chip selects: one per window plus default region.
// - Unlatched bit bypasses chip-select latch, decoding straight from address.
// - Ready input lets slow devices stretch the access until ready.
// - Arbitration enable hands request, acknowledge and hold pins to the unit.
// - Master after reset; slave select bit turns acknowledge into an input.
// - Address space limit drives eight, four, two or no upper address lines.
`include "ebu_defs.vh"
module ebu_external_bus_unit (
    input  wire                         mclk,
    input  wire                         rst_n,
    input  wire                         req_valid,
    output wire                         req_ready,
    input  wire                         req_write,
    input  wire [`EBU_AW-1:0]           req_addr,
    input  wire [`EBU_DW-1:0]           req_wdata,
    output reg                          resp_valid,
    output reg  [`EBU_DW-1:0]           resp_rdata,
    input  wire                         single_chip,
    input  wire [`EBU_NWIN*16-1:0]      window_select_reg,
    input  wire [`EBU_NWIN*16-1:0]      window_bus_config_reg,
    input  wire [`EBU_CFGW-1:0]         default_bus_config_reg,
    input  wire [`EBU_CFGW-1:0]         system_config_reg,
    input  wire [`EBU_CFGW-1:0]         processor_status_word,
    input  wire                         slave_select_dir_bit,
    output wire [`EBU_DW-1:0]           address_port_o,
    output wire                         address_port_oe,
    output wire [7:0]                   upper_addr_o,
    output wire [7:0]                   upper_addr_oe,
    output wire [`EBU_DW-1:0]           data_port_o,
    input  wire [`EBU_DW-1:0]           data_port_i,
    output wire [`EBU_DW-1:0]           data_port_oe,
    output wire                         ale,
    output wire                         rd_n,
    output wire                         wr_n,
    output wire                         ctrl_oe,
    output wire [`EBU_NCS-1:0]          cs_n,
    input  wire                         ready_n,
    input  wire                         hold_n,
    output wire                         hold_ack_pin_o,
    input  wire                         hold_ack_pin_i,
    output wire                         hold_ack_pin_oe,
    output wire                         bus_request_pin_o,
    output wire                         bus_request_pin_oe
);

    // =================================================================
    // States
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ALE  = 7'h02;
    localparam [6:0] S_DLY  = 7'h04;
    localparam [6:0] S_ACC  = 7'h08;
    localparam [6:0] S_TRI  = 7'h10;
    localparam [6:0] S_HOLD = 7'h20;
    localparam [6:0] S_GNT  = 7'h40;

    reg  [6:0]              state_r;
    reg  [6:0]              state_nxt;
    reg  [`EBU_CNTW-1:0]    cnt_r;
    reg  [`EBU_CNTW-1:0]    cnt_nxt;
    reg  [`EBU_AW-1:0]      addr_r;
    reg  [`EBU_DW-1:0]      wdata_r;
    reg                     write_r;
    reg  [`EBU_CFGW-1:0]    cfg_r;
    reg  [`EBU_NCS-1:0]     cs_lat_r;
    reg                     arb_on_r;
    wire [`EBU_NCS-1:0]     req_hit;
    wire [`EBU_NCS-1:0]     addr_hit;
    wire [`EBU_NWIN-1:0]    win_act;
    reg  [`EBU_CFGW-1:0]    sel_cfg;

    // =================================================================
    // Window decoding
    genvar g;
    generate
        for (g = 0; g < `EBU_NWIN; g = g + 1) begin : g_act
            assign win_act[g] =
                window_bus_config_reg[g*16 + `EBU_CFG_ACT];
        end
    endgenerate

    ebu_window_decode u_req_dec (
        .addr     (req_addr),
        .sel_regs (window_select_reg),
        .win_act  (win_act),
        .win_hit  (req_hit)
    );

    ebu_window_decode u_bus_dec (
        .addr     (addr_r),
        .sel_regs (window_select_reg),
        .win_act  (win_act),
        .win_hit  (addr_hit)
    );

    integer k;
    always @* begin
        sel_cfg = default_bus_config_reg;
        for (k = 0; k < `EBU_NWIN; k = k + 1) begin
            if (req_hit[k+1]) begin
                sel_cfg = window_bus_config_reg[k*16 +: 16];
            end
        end
    end

    // =================================================================
    // Arbitration
    wire arb_en    = arb_on_r;
    wire slave     = arb_en & slave_select_dir_bit;
    wire granted   = ~slave | ~hold_ack_pin_i;
    wire hold_req  = arb_en & ~slave & ~hold_n;
    wire in_hold   = (state_r == S_HOLD);
    wire float_bus = in_hold | (slave & (state_r == S_IDLE) & ~granted);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arb_on_r <= 1'b0;
        end else if (processor_status_word[`EBU_PSW_ARB_EN]) begin
            arb_on_r <= 1'b1;
        end
    end

    // =================================================================
    // Bus cycle sequencer
    wire cfg_mux  = cfg_r[`EBU_CFG_MODE_LO + `EBU_MODE_MUX];
    wire cfg_w16  = cfg_r[`EBU_CFG_MODE_LO + `EBU_MODE_W16];
    wire acc_done = (cnt_r == `EBU_CNT_ZERO) &
                    (~cfg_r[`EBU_CFG_RDY_EN] | ~ready_n);

    assign req_ready = (state_r == S_IDLE) & ~single_chip & ~hold_req &
                       granted;

    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            S_IDLE: begin
                if (hold_req) begin
                    state_nxt = S_HOLD;
                end else if (req_valid && req_ready) begin
                    state_nxt = S_ALE;
                    cnt_nxt   = sel_cfg[`EBU_CFG_ALE_EXT] ?
                                `EBU_ALE_LONG : `EBU_ALE_SHORT;
                end
            end
            S_ALE: begin
                if (cnt_r != `EBU_CNT_ZERO) begin
                    cnt_nxt = cnt_r - `EBU_CNT_ONE;
                end else if (cfg_r[`EBU_CFG_RW_DLY]) begin
                    state_nxt = S_DLY;
                end else begin
                    state_nxt = S_ACC;
                    cnt_nxt   = cfg_r[`EBU_CFG_MCT_HI:`EBU_CFG_MCT_LO];
                end
            end
            S_DLY: begin
                state_nxt = S_ACC;
                cnt_nxt   = cfg_r[`EBU_CFG_MCT_HI:`EBU_CFG_MCT_LO];
            end
            S_ACC: begin
                if (acc_done) begin
                    state_nxt = (cfg_r[`EBU_CFG_TRI] && !write_r) ?
                                S_TRI : S_IDLE;
                end else if (cnt_r != `EBU_CNT_ZERO) begin
                    cnt_nxt = cnt_r - `EBU_CNT_ONE;
                end
            end
            S_TRI: begin
                state_nxt = S_IDLE;
            end
            S_HOLD: begin
                if (hold_n) begin
                    state_nxt = S_GNT;
                end
            end
            S_GNT: begin
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= S_IDLE;
            cnt_r      <= `EBU_CNT_ZERO;
            addr_r     <= {`EBU_AW{1'b0}};
            wdata_r    <= {`EBU_DW{1'b0}};
            write_r    <= 1'b0;
            cfg_r      <= `EBU_CFG_RESET;
            cs_lat_r   <= {`EBU_NCS{1'b0}};
            resp_valid <= 1'b0;
            resp_rdata <= {`EBU_DW{1'b0}};
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            resp_valid <= 1'b0;
            if (state_r == S_IDLE && req_valid && req_ready) begin
                addr_r   <= req_addr;
                wdata_r  <= req_wdata;
                write_r  <= req_write;
                cfg_r    <= sel_cfg;
                cs_lat_r <= req_hit;
            end
            if (state_r == S_ACC && acc_done) begin
                resp_valid <= 1'b1;
                cs_lat_r   <= {`EBU_NCS{1'b0}};
                if (!write_r) begin
                    resp_rdata <= cfg_w16 ? data_port_i :
                        {8'h00, data_port_i[7:0]};
                end
            end
        end
    end

    // =================================================================
    // Pin drive
    wire busy     = ~(state_r == S_IDLE) & ~in_hold & ~(state_r == S_GNT);
    wire addr_ph  = (state_r == S_ALE) | (state_r == S_DLY);
    wire wr_ph    = (state_r == S_ACC) & write_r;
    wire [1:0] spc = system_config_reg[`EBU_SYS_SPC_HI:`EBU_SYS_SPC_LO];
    reg  [7:0] up_mask;

    always @* begin
        case (spc)
            `EBU_SPC_64K:  up_mask = `EBU_UPM_64K;
            `EBU_SPC_256K: up_mask = `EBU_UPM_256K;
            `EBU_SPC_1M:   up_mask = `EBU_UPM_1M;
            default:       up_mask = `EBU_UPM_16M;
        endcase
    end

    assign address_port_o  = addr_r[`EBU_DW-1:0];
    assign address_port_oe = ~float_bus & ~cfg_mux & ~single_chip;
    assign upper_addr_o    = addr_r[`EBU_AW-1:`EBU_DW] & up_mask;
    assign upper_addr_oe   = (float_bus | single_chip) ? 8'h00 : up_mask;

    assign data_port_o  = (cfg_mux && addr_ph) ? addr_r[`EBU_DW-1:0] :
                          wdata_r;
    assign data_port_oe = ~busy ? {`EBU_DW{1'b0}} :
                          (cfg_mux && addr_ph) ? {`EBU_DW{1'b1}} :
                          !wr_ph ? {`EBU_DW{1'b0}} :
                          cfg_w16 ? {`EBU_DW{1'b1}} : 16'h00ff;

    assign ale     = (state_r == S_ALE);
    assign rd_n    = ~((state_r == S_ACC) & ~write_r);
    assign wr_n    = ~wr_ph;
    assign ctrl_oe = ~float_bus & ~single_chip;

    // Latched selects hold for the cycle; unlatched follow the address.
    assign cs_n = float_bus ? {`EBU_NCS{1'b1}} :
                  system_config_reg[`EBU_SYS_UNLATCHED_CS_CFG] ? ~addr_hit :
                  ~cs_lat_r;

    assign hold_ack_pin_o     = ~in_hold;
    assign hold_ack_pin_oe    = arb_en & ~slave;
    assign bus_request_pin_o  = ~((slave & req_valid & ~granted) |
                                  (in_hold & req_valid));
    assign bus_request_pin_oe = arb_en;

endmodule // ebu_external_bus_unit

//--- ebu_bus_sva.sv
// Checker for the pins and handshake of the external bus unit.
// Assumes it is bound onto ebu_external_bus_unit by port name.
module ebu_bus_sva (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        resp_valid,
    input wire logic        single_chip,
    input wire logic [15:0] system_config_reg,
    input wire logic [15:0] processor_status_word,
    input wire logic        slave_select_dir_bit,
    input wire logic        address_port_oe,
    input wire logic [7:0]  upper_addr_o,
    input wire logic [7:0]  upper_addr_oe,
    input wire logic [15:0] data_port_oe,
    input wire logic        ale,
    input wire logic        rd_n,
    input wire logic        ctrl_oe,
    input wire logic [4:0]  cs_n,
    input wire logic        hold_n,
    input wire logic        hold_ack_pin_o,
    input wire logic        hold_ack_pin_oe,
    input wire logic        bus_request_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       arb_seen_r;
    logic [1:0] sp;
    logic [7:0] spc_mask;
    // ========
    // Helper logic.
    assign sp = system_config_reg[10:9];
    assign spc_mask = sp[1] ? (sp[0] ? 8'hff : 8'h0f) : {6'h00, sp[0], sp[0]};
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            arb_seen_r <= 1'b0;
        else if (processor_status_word[10])
            arb_seen_r <= 1'b1;
    // ========
    // Assertions.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chip_only_a: assert property (
        single_chip |-> !req_ready) else $error("single chip took request");
    read_float_a: assert property (
        !rd_n |-> data_port_oe == 16'h0000) else $error("driving on read");
    mux_addr_a: assert property (
        ale && ctrl_oe && !address_port_oe |-> data_port_oe == 16'hffff)
        else $error("mux address not driven");
    one_select_a: assert property (
        $onehot0(~cs_n)) else $error("several chip selects");
    latched_cs_a: assert property (
        req_valid && req_ready && !system_config_reg[6] |-> cs_n == 5'h1f)
        else $error("latched select active when idle");
    arb_off_a: assert property (
        !arb_seen_r |-> !hold_ack_pin_oe && !bus_request_pin_oe)
        else $error("arbitration pins driven early");
    slave_in_a: assert property (
        slave_select_dir_bit && $past(slave_select_dir_bit) |->
        !hold_ack_pin_oe) else $error("acknowledge driven in slave");
    space_mask_a: assert property (
        $stable(system_config_reg) |->
        ((upper_addr_o | upper_addr_oe) & ~spc_mask) == 8'h00)
        else $error("upper address beyond space");
    hold_float_a: assert property (
        hold_ack_pin_oe && !hold_ack_pin_o |-> !ctrl_oe && !address_port_oe
        && data_port_oe == 16'h0000) else $error("bus driven while held");
    hold_grant_a: assert property (
        !hold_n && hold_ack_pin_oe && !slave_select_dir_bit |->
        ##[0:40] (hold_n || !hold_ack_pin_o)) else $error("hold not granted");
    resp_pulse_a: assert property (
        resp_valid |=> !resp_valid) else $error("response too long");
endmodule // ebu_bus_sva

bind ebu_external_bus_unit ebu_bus_sva u_sva (.mclk, .rst_n, .req_valid,
    .req_ready, .resp_valid, .single_chip, .system_config_reg,
    .processor_status_word, .slave_select_dir_bit, .address_port_oe,
    .upper_addr_o, .upper_addr_oe, .data_port_oe, .ale, .rd_n, .ctrl_oe,
    .cs_n, .hold_n, .hold_ack_pin_o, .hold_ack_pin_oe, .bus_request_pin_oe);

//--- ebu_mem_model.sv
// Behavioural external memory answering the bus unit.
// Assumes low-active strobes; ready latency is set by the bench.
module ebu_mem_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  lat,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        address_port_oe,
    input  wire logic [15:0] address_port_o,
    input  wire logic [15:0] data_port_o,
    output logic      [15:0] data_port_i,
    output logic             ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] addr_r;
    logic [15:0] junk_r;
    logic [3:0]  cnt_r;
    // ========
    // Address latch, read data and ready.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 16'h0000;
            junk_r <= 16'h5a5a;
            cnt_r <= 4'h0;
        end else begin
            junk_r <= ~junk_r;
            if (ale)
                addr_r <= address_port_oe ? address_port_o : data_port_o;
            cnt_r <= (!rd_n || !wr_n) ? cnt_r + 4'h1 : 4'h0;
        end
    end
    assign data_port_i = rd_n ? junk_r : addr_r ^ 16'ha5c3;
    assign ready_n = !((!rd_n || !wr_n) && cnt_r >= lat);
endmodule // ebu_mem_model

//--- ebu_external_bus_unit_tb_top.sv
// Self-checking bench for the external bus unit.
// Assumes the memory model and the bound checker are compiled alongside.
module ebu_external_bus_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic wr; logic w8; logic [4:0] cs; logic [15:0] d;
    } ebu_note_t;
    logic        mclk, rst_n, req_valid, req_ready, req_write, resp_valid;
    logic        single_chip, slave_select_dir_bit, address_port_oe, ale;
    logic        rd_n, wr_n, ctrl_oe, ready_n, hold_n, hold_ack_pin_o;
    logic        hold_ack_pin_i, hold_ack_pin_oe, bus_request_pin_o;
    logic        bus_request_pin_oe, grant_n;
    logic [23:0] req_addr;
    logic [15:0] req_wdata, resp_rdata, default_bus_config_reg, wd_seen;
    logic [15:0] system_config_reg, processor_status_word, address_port_o;
    logic [15:0] data_port_o, data_port_i, data_port_oe;
    logic [15:0] cfg [5];
    logic [63:0] window_select_reg, window_bus_config_reg;
    logic [23:0] al [6];
    logic [7:0]  upper_addr_o, upper_addr_oe;
    logic [4:0]  cs_n, cs_seen;
    logic [3:0]  lat;
    ebu_note_t   notes [$];
    ebu_note_t   nt;
    int          fail_count, check_count, k;
    ebu_external_bus_unit u_dut (.mclk, .rst_n, .req_valid, .req_ready,
        .req_write, .req_addr, .req_wdata, .resp_valid, .resp_rdata,
        .single_chip, .window_select_reg, .window_bus_config_reg,
        .default_bus_config_reg, .system_config_reg, .processor_status_word,
        .slave_select_dir_bit, .address_port_o, .address_port_oe,
        .upper_addr_o, .upper_addr_oe, .data_port_o, .data_port_i,
        .data_port_oe, .ale, .rd_n, .wr_n, .ctrl_oe, .cs_n, .ready_n,
        .hold_n, .hold_ack_pin_o, .hold_ack_pin_i, .hold_ack_pin_oe,
        .bus_request_pin_o, .bus_request_pin_oe);
    ebu_mem_model u_mem (.mclk, .rst_n, .lat, .ale, .rd_n, .wr_n,
        .address_port_oe, .address_port_o, .data_port_o, .data_port_i,
        .ready_n);
    assign hold_ack_pin_i = hold_ack_pin_oe ? hold_ack_pin_o : grant_n;
    always #2 mclk = ~mclk;
    // ========
    // Tasks.
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic int exp_win(input logic [23:0] a);
        if (a[23:12] == 12'h020) return 4;
        if (a[23:16] == 8'h02) return 3;
        if (a[23:12] == 12'h018) return 2;
        if (a[23:16] == 8'h01) return 1;
        return 0;
    endfunction
    task automatic acc(input logic wr, input logic [23:0] a);
        int i;
        int n;
        logic [15:0] r;
        i = exp_win(a);
        r = wr ? 16'($urandom) : a[15:0] ^ 16'ha5c3;
        @(negedge mclk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = r;
        lat = 4'($urandom % 4);
        notes.push_back({wr, !cfg[i][8], ~(5'h01 << i),
                         cfg[i][8] ? r : {8'h00, r[7:0]}});
        for (n = 0; n < 100 && req_ready !== 1'b1; n++)
            @(negedge mclk);
        @(posedge mclk);
    endtask
    // ========
    // Monitor: pairs each finished access with the oldest note.
    always @(negedge mclk) begin
        if (!rd_n || !wr_n)
            cs_seen = cs_n;
        if (!wr_n)
            wd_seen = data_port_o;
        if (resp_valid && notes.size() > 0) begin
            nt = notes.pop_front();
            chk({11'h000, nt.cs}, {11'h000, cs_seen});
            chk(nt.d, nt.wr ? (nt.w8 ? {8'h00, wd_seen[7:0]} : wd_seen)
                : resp_rdata);
        end else if (resp_valid) begin
            chk(16'h0001, 16'h0000);
        end
    end
    initial begin
        #50000;
        chk(16'h0001, 16'h0000);
        tally_and_finish;
    end
    // ========
    // Main sequence.
    initial begin
        void'($urandom(6721));
        {mclk, rst_n, req_valid, req_write, single_chip, lat} = '0;
        {slave_select_dir_bit, hold_n, grant_n} = 3'h3 >> 1;
        hold_n = 1'b1;
        {req_addr, req_wdata, system_config_reg} = '0;
        system_config_reg[10:9] = 2'h3;
        processor_status_word = 16'h0000;
        fail_count = 0;
        check_count = 0;
        cfg = '{16'h0301, 16'h0762, 16'h0590, 16'h0400, 16'h0683};
        default_bus_config_reg = cfg[0];
        window_bus_config_reg = {cfg[4], cfg[3], cfg[2], cfg[1]};
        window_select_reg = {16'h0200, 16'h0204, 16'h0180, 16'h0104};
        al = '{24'h000100, 24'h01f000, 24'h018010, 24'h020020,
               24'h02f000, 24'h0ff000};
        repeat (8) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        for (k = 0; k < 12; k++)
            acc(k[0], al[k / 2]);
        for (k = 0; k < 24; k++) begin
            if (k % 12 == 0)
                @(negedge mclk) system_config_reg[6] = k[3] | k[4];
            acc(1'($urandom), {al[$urandom % 6][23:12], 12'($urandom)});
        end
        for (k = 0; k < 4; k++) begin
            @(negedge mclk) system_config_reg[10:9] = 2'(k);
            acc(1'b0, 24'h0f0100 + 24'(k));
            @(negedge mclk);
            chk(16'(k == 0 ? 0 : (k == 1 ? 3 : 15)),
                {8'h00, upper_addr_o});
        end
        @(negedge mclk);
        req_valid = 1'b0;
        single_chip = 1'b1;
        repeat (3) @(negedge mclk);
        req_valid = 1'b1;
        repeat (3) @(negedge mclk);
        chk(16'h0000, {15'h0000, req_ready});
        req_valid = 1'b0;
        single_chip = 1'b0;
        processor_status_word[10] = 1'b1;
        acc(1'b0, 24'h018020);
        @(negedge mclk);
        req_valid = 1'b0;
        hold_n = 1'b0;
        for (k = 0; k < 60 && hold_ack_pin_o !== 1'b0; k++)
            @(negedge mclk);
        chk(16'h0000, {15'h0000, hold_ack_pin_o});
        chk(16'h0000, data_port_oe);
        hold_n = 1'b1;
        acc(1'b1, 24'h020040);
        @(negedge mclk);
        req_valid = 1'b0;
        slave_select_dir_bit = 1'b1;
        repeat (3) @(negedge mclk);
        req_valid = 1'b1;
        repeat (3) @(negedge mclk);
        chk(16'h0000, {15'h0000, req_ready});
        chk(16'h0000, {15'h0000, bus_request_pin_o});
        req_valid = 1'b0;
        grant_n = 1'b0;
        acc(1'b0, 24'h01f100);
        @(negedge mclk) req_valid = 1'b0;
        repeat (40) @(posedge mclk);
        chk(16'h0000, 16'(notes.size()));
        tally_and_finish;
    end
endmodule // ebu_external_bus_unit_tb_top
